//--- serial_flash_status_protect.sv
// Notes on behaviour
// - a complete latch-clear command drops the write-enable latch when not busy.
// - latch clears at reset and after clear, status write, program, erase.
// - status read is accepted any time, even during a busy cycle.
// - status byte repeats while select stays low after a status read.
// - busy reads 1 during a status write, program or erase cycle.
// - latch at 0 refuses status write, program and erase.
// - protect bits are kept; program and erase into protected area refused.
// - chip erase runs only with all protect bits zero.
// - lock bit 1 with protect pin low locks the status bits.
// - status write needs an earlier latch-set.
// - status write is code plus one byte; other select rise discards it.
// - status write leaves b6,b5,b1,b0; b6 and b5 always read zero.
// - valid status write runs a t_W busy cycle, then clears latch.
// - status write loads protect bits and lock bit from data byte.
// - lock bit 0 allows status writes whatever the protect pin level.
// - lock bit 1 with protect pin high still allows status writes.
// - locked mode follows lock and pin in either order.
// - only a high protect pin leaves locked mode.
// - latch-set completion sets the write-enable latch when not busy.
// - bits shift msb first, sampled on rising serial clock.
// - latch and status-write commands need select rise on byte boundary.
`timescale 1ns/10ps
`include "flash_status_cfg.svh"
module serial_flash_status_protect #(
	parameter int T_W_CYCLES = `T_W_CYCLES,
	parameter logic [7:0] NV_DEFAULT = `SR_RESET
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic chip_sel_n,
	input wire logic serial_clk,
	input wire logic serial_data_input,
	input wire logic write_protect_n,
	// cycles run by the array datapath outside this block
	input wire logic array_cycle_busy,
	input wire logic array_cycle_done,
	// address of a pending program/erase lies in the selected protect area
	input wire logic array_addr_protected,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic [7:0] status_register,
	output logic hardware_locked_mode,
	output logic software_locked_mode,
	output logic program_grant,
	output logic chip_wipe_grant
);

	typedef struct packed {
		logic [2:0] pins;
		logic sclk_d;
		logic csn_d;
		flash_status_pkg::shift_state_type sh;
		flash_status_pkg::status_fields_type sr;
		logic [31:0] wcnt;
		logic wr_cycle;
		logic prog_grant;
		logic chip_grant;
		logic do_r;
		logic oe_r;
	} state_type;

	state_type st_r;
	state_type st_nxt;
	logic [3:0] pins_sync;

	pin_sync #(
		.WIDTH(4)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in({chip_sel_n, serial_clk, serial_data_input,
			write_protect_n}),
		.sync_out(pins_sync)
	);

	function automatic logic [7:0] pack_status(
		input flash_status_pkg::status_fields_type f);
		logic [7:0] v;
		v = 8'h00;
		v[`SR_BUSY] = f.busy;
		v[`SR_WEL] = f.write_enable_latch;
		v[`SR_BP_HI:`SR_BP_LO] = f.nv.bp;
		v[`SR_LOCK] = f.nv.lock;
		return v; // b6 and b5 stay zero
	endfunction : pack_status

	function automatic logic is_array_write(input logic [7:0] c);
		return c == `CMD_PAGE_PROGRAM || c == `CMD_SECTOR_WIPE ||
			c == `CMD_BLOCK_WIPE;
	endfunction : is_array_write

	logic csn;
	logic sclk;
	logic din;
	logic wp_n;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic hw_lock;
	logic [7:0] byte_in;
	logic [7:0] cur_status;

	assign csn = pins_sync[3];
	assign sclk = pins_sync[2];
	assign din = pins_sync[1];
	assign wp_n = pins_sync[0];

	always_comb
	begin
		sclk_rise = sclk & ~st_r.sclk_d & ~csn;
		sclk_fall = ~sclk & st_r.sclk_d & ~csn;
		cs_fall = ~csn & st_r.csn_d;
		cs_rise = csn & ~st_r.csn_d;
		// level, so entering works in either order
		hw_lock = st_r.sr.nv.lock & ~wp_n;
		byte_in = {st_r.sh.sh[6:0], din}; // msb first
		cur_status = pack_status(st_r.sr);
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sclk_d = sclk;
		st_nxt.csn_d = csn;
		st_nxt.prog_grant = 1'b0;
		st_nxt.chip_grant = 1'b0;

		// busy covers own status cycle and array cycles
		st_nxt.sr.busy = st_r.wr_cycle | array_cycle_busy;

		if (st_r.wr_cycle)
		begin
			if (st_r.wcnt == 32'd1)
			begin
				st_nxt.wr_cycle = 1'b0;
				st_nxt.sr.write_enable_latch = 1'b0;
				st_nxt.sr.busy = array_cycle_busy;
			end
			st_nxt.wcnt = st_r.wcnt - 32'd1;
		end

		if (array_cycle_done)
		begin
			st_nxt.sr.write_enable_latch = 1'b0;
		end

		if (cs_fall)
		begin
			st_nxt.sh = '0;
			st_nxt.sh.phase = flash_status_pkg::ph_cmd;
			st_nxt.oe_r = 1'b0;
		end
		else if (!csn && sclk_rise)
		begin
			st_nxt.sh.sh = byte_in;
			st_nxt.sh.bitcnt = st_r.sh.bitcnt + 3'd1;
			st_nxt.sh.misaligned = (st_r.sh.bitcnt != 3'd7);
			if (st_r.sh.bitcnt == 3'd7)
			begin
				case (st_r.sh.phase)
					flash_status_pkg::ph_cmd:
					begin
						st_nxt.sh.cmd = byte_in;
						st_nxt.sh.bytes_done = 1'b0;
						if (byte_in == `CMD_STATUS_READ)
						begin
							// accepted even mid-cycle
							st_nxt.sh.phase = flash_status_pkg::ph_out;
							st_nxt.sh.out_sh = cur_status;
						end
						else if (byte_in == `CMD_STATUS_WRITE)
						begin
							st_nxt.sh.phase = flash_status_pkg::ph_data;
						end
						else
						begin
							st_nxt.sh.phase = flash_status_pkg::ph_ignore;
						end
					end
					flash_status_pkg::ph_data:
					begin
						if (!st_r.sh.bytes_done)
						begin
							st_nxt.sh.data = byte_in;
							st_nxt.sh.bytes_done = 1'b1;
						end
						else
						begin
							// extra byte spoils the write
							st_nxt.sh.phase = flash_status_pkg::ph_ignore;
							st_nxt.sh.bytes_done = 1'b0;
						end
					end
					default:
					begin
						st_nxt.sh.phase = st_r.sh.phase;
					end
				endcase
			end
		end
		else if (!csn && sclk_fall &&
			st_r.sh.phase == flash_status_pkg::ph_out)
		begin
			st_nxt.oe_r = 1'b1;
			st_nxt.do_r = st_r.sh.out_sh[7];
			if (st_r.sh.bitcnt == 3'd0)
			begin
				// reload byte; repeats while select low
				st_nxt.sh.out_sh = {cur_status[6:0], 1'b0};
				st_nxt.do_r = cur_status[7];
			end
			else
			begin
				st_nxt.sh.out_sh = {st_r.sh.out_sh[6:0], 1'b0};
			end
		end

		if (cs_rise)
		begin
			st_nxt.oe_r = 1'b0;
			st_nxt.sh.phase = flash_status_pkg::ph_ignore;
			// byte boundary required
			if (!st_r.sh.misaligned && st_r.sh.bitcnt == 3'd0 &&
				!st_r.sr.busy)
			begin
				case (st_r.sh.cmd)
					`CMD_LATCH_SET:
					begin
						if (st_r.sh.phase == flash_status_pkg::ph_ignore)
						begin
							st_nxt.sr.write_enable_latch = 1'b1;
						end
					end
					`CMD_LATCH_CLEAR:
					begin
						if (st_r.sh.phase == flash_status_pkg::ph_ignore)
						begin
							st_nxt.sr.write_enable_latch = 1'b0;
						end
					end
					`CMD_STATUS_WRITE:
					begin
						// one data byte, latch set, not locked
						if (st_r.sh.phase == flash_status_pkg::ph_data &&
							st_r.sh.bytes_done && st_r.sr.write_enable_latch && !hw_lock)
						begin
							// only lock and protect bits change
							st_nxt.sr.nv.bp =
								st_r.sh.data[`SR_BP_HI:`SR_BP_LO];
							st_nxt.sr.nv.lock = st_r.sh.data[`SR_LOCK];
							st_nxt.wr_cycle = 1'b1;
							st_nxt.wcnt = 32'(T_W_CYCLES);
							st_nxt.sr.busy = 1'b1;
						end
					end
					`CMD_CHIP_WIPE:
					begin
						st_nxt.chip_grant = st_r.sr.write_enable_latch &&
							st_r.sr.nv.bp == 3'b000;
					end
					default:
					begin
						st_nxt.prog_grant = is_array_write(st_r.sh.cmd) &&
							st_r.sr.write_enable_latch && !array_addr_protected;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.sclk_d <= 1'b0;
			st_r.csn_d <= 1'b1;
			st_r.sh.phase <= flash_status_pkg::ph_ignore;
			// protect bits persist: default stands for stored value
			st_r.sr.nv.bp <= NV_DEFAULT[`SR_BP_HI:`SR_BP_LO];
			st_r.sr.nv.lock <= NV_DEFAULT[`SR_LOCK];
			st_r.sr.write_enable_latch <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign serial_data_out = st_r.do_r;
	assign serial_data_oe = st_r.oe_r;
	assign status_register = cur_status;
	assign hardware_locked_mode = hw_lock;
	assign software_locked_mode = ~hw_lock;
	assign program_grant = st_r.prog_grant;
	assign chip_wipe_grant = st_r.chip_grant;

endmodule : serial_flash_status_protect

//--- flash_status_cfg.svh
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

`define CMD_LATCH_SET 8'h06
`define CMD_LATCH_CLEAR 8'h04
`define CMD_STATUS_READ 8'h05
`define CMD_STATUS_WRITE 8'h01
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_SECTOR_WIPE 8'h20
`define CMD_BLOCK_WIPE 8'hd8
`define CMD_CHIP_WIPE 8'hc7

`define SR_BUSY 0
`define SR_WEL 1
`define SR_BP_LO 2
`define SR_BP_HI 4
`define SR_LOCK 7
`define SR_RESET 8'h00

// self-timed status write cycle, in ns
`define T_W_NS 5000000
`define CLK_NS 10
`define T_W_CYCLES ((`T_W_NS + `CLK_NS - 1) / `CLK_NS)

`endif

//--- flash_status_pkg.sv
package flash_status_pkg;

	typedef struct packed {
		logic lock;
		logic [2:0] bp;
	} nv_bits_type;

	typedef struct packed {
		logic busy;
		logic write_enable_latch;
		nv_bits_type nv;
	} status_fields_type;

	typedef enum logic [1:0] {
		ph_cmd,
		ph_data,
		ph_out,
		ph_ignore
	} phase_type;

	typedef struct packed {
		logic [7:0] cmd;
		logic [2:0] bitcnt;
		logic bytes_done;
		logic misaligned;
		logic [7:0] sh;
		logic [7:0] data;
		phase_type phase;
		logic [7:0] out_sh;
	} shift_state_type;

endpackage : flash_status_pkg

//--- pin_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for asynchronous pin levels
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_state_type;

	sync_state_type st_r;
	sync_state_type st_nxt;

	always_comb
	begin
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			// idle high: select and protect pins, so no false edge
			// after reset; clock edges are gated by select
			st_r <= '1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.s2;

endmodule : pin_sync

//--- flash_status_sva.sv
`timescale 1ns/10ps
module flash_status_sva #(
	parameter int T_W_CYCLES = 20
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic chip_sel_n,
	input wire logic serial_clk,
	input wire logic serial_data_input,
	input wire logic write_protect_n,
	input wire logic array_cycle_busy,
	input wire logic array_cycle_done,
	input wire logic array_addr_protected,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic [7:0] status_register,
	input wire logic hardware_locked_mode,
	input wire logic software_locked_mode,
	input wire logic program_grant,
	input wire logic chip_wipe_grant
);
	logic [31:0] busy_len_r;
	logic [31:0] busy_len_nxt;
	always_comb
	begin
		busy_len_nxt = status_register[0] ? busy_len_r + 32'h1 : 32'h0;
	end
	always_ff @(posedge mclk)
	begin
		busy_len_r <= rst_n ? busy_len_nxt : 32'h0;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence locked_twice;
		hardware_locked_mode ##1 hardware_locked_mode;
	endsequence
	sequence write_end;
		$fell(status_register[0]) && !$past(array_cycle_busy, 2);
	endsequence
	zero_bits_a: assert property (status_register[6:5] == 2'b00)
		else $error("b6 b5 not zero");
	mode_pair_a: assert property (software_locked_mode != hardware_locked_mode)
		else $error("modes not exclusive");
	lock_bit_a: assert property (hardware_locked_mode |-> status_register[7])
		else $error("locked without lock bit");
	locked_stable_a: assert property (locked_twice |-> $stable(status_register[7:2]))
		else $error("locked bits changed");
	wipe_open_a: assert property (status_register[4:2] != 3'h0 |-> !chip_wipe_grant)
		else $error("chip wipe while protected");
	grant_latch_a: assert property ((program_grant || chip_wipe_grant) |->
		$past(status_register[1]) && !$past(status_register[0]))
		else $error("grant without latch");
	array_busy_a: assert property (array_cycle_busy && $past(array_cycle_busy)
		|-> status_register[0])
		else $error("busy flag missing");
	write_length_a: assert property (write_end |-> busy_len_r == T_W_CYCLES)
		else $error("write cycle length");
	write_latch_a: assert property (write_end |-> ##[0:1] !status_register[1])
		else $error("latch kept after write");
	done_clears_a: assert property (array_cycle_done |-> ##[1:3] !status_register[1])
		else $error("latch kept after array cycle");
	idle_quiet_a: assert property (chip_sel_n [*5] |-> !serial_data_oe)
		else $error("output driven while idle");
endmodule : flash_status_sva

bind serial_flash_status_protect flash_status_sva #(.T_W_CYCLES(T_W_CYCLES)) sva
(
	.mclk(mclk), .rst_n(rst_n), .chip_sel_n(chip_sel_n),
	.serial_clk(serial_clk), .serial_data_input(serial_data_input),
	.write_protect_n(write_protect_n), .array_cycle_busy(array_cycle_busy),
	.array_cycle_done(array_cycle_done),
	.array_addr_protected(array_addr_protected),
	.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
	.status_register(status_register),
	.hardware_locked_mode(hardware_locked_mode),
	.software_locked_mode(software_locked_mode),
	.program_grant(program_grant), .chip_wipe_grant(chip_wipe_grant)
);

//--- spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
	output logic chip_sel_n,
	output logic serial_clk,
	output logic serial_data_input,
	input wire logic serial_data_out
);
	initial
	begin
		chip_sel_n = 1'b1;
		serial_clk = 1'b0;
		serial_data_input = 1'b0;
	end
	// clock idles low outside frames; bits after the code are read back
	task frame(input logic [31:0] bits, input int n, output logic [15:0] rd);
		rd = 16'h0;
		chip_sel_n = 1'b0;
		#100;
		for (int i = 0; i < n; i++)
		begin
			serial_data_input = bits[31-i];
			#62.5 serial_clk = 1'b1;
			if (i >= 8)
				rd = {rd[14:0], serial_data_out};
			#62.5 serial_clk = 1'b0;
		end
		#100 chip_sel_n = 1'b1;
		serial_data_input = ~serial_data_input;
		#200;
	endtask : frame
endmodule : spi_host_model

//--- serial_flash_status_protect_test.sv
`timescale 1ns/10ps
`include "flash_status_cfg.svh"
module serial_flash_status_protect_test;
	localparam int TW = 1000;
	typedef struct packed {
		logic wp;
		logic [7:0] data;
		logic [7:0] sr;
		logic hw;
	} row_type;
	row_type rows [5] = '{'{1'b1, 8'hff, 8'h9c, 1'b0},
		'{1'b0, 8'h00, 8'h9e, 1'b1}, '{1'b1, 8'h00, 8'h00, 1'b0},
		'{1'b0, 8'h9c, 8'h9c, 1'b1}, '{1'b1, 8'h00, 8'h00, 1'b0}};
	logic mclk, rst_n, chip_sel_n, serial_clk, serial_data_input;
	logic write_protect_n, array_cycle_busy, array_cycle_done;
	logic serial_data_out, serial_data_oe, hardware_locked_mode;
	logic software_locked_mode, program_grant, chip_wipe_grant;
	logic [7:0] status_register;
	logic [15:0] rd;
	logic array_addr_protected;
	int error_cnt, check_count, cyc, grants, pgrants;
	serial_flash_status_protect #(.T_W_CYCLES(TW)) dut (.mclk(mclk),
		.rst_n(rst_n), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
		.serial_data_input(serial_data_input),
		.write_protect_n(write_protect_n),
		.array_cycle_busy(array_cycle_busy),
		.array_cycle_done(array_cycle_done),
		.array_addr_protected(array_addr_protected),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
		.status_register(status_register),
		.hardware_locked_mode(hardware_locked_mode),
		.software_locked_mode(software_locked_mode),
		.program_grant(program_grant), .chip_wipe_grant(chip_wipe_grant));
	spi_host_model host (.chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
		.serial_data_input(serial_data_input),
		.serial_data_out(serial_data_out));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task tally_and_finish();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge mclk)
	begin
		cyc++;
		if (chip_wipe_grant === 1'b1)
			grants++;
		if (program_grant === 1'b1)
			pgrants++;
		if (cyc == 40000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task cycles(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cycles
	task cmd(input logic [7:0] c, input int n);
		host.frame({c, 24'h0}, n, rd);
	endtask : cmd
	task status_write_cmd(input logic [7:0] d, input int n);
		host.frame({`CMD_STATUS_WRITE, d, 16'h0}, n, rd);
	endtask : status_write_cmd
	task poll_idle();
		int k;
		k = 0;
		cmd(`CMD_STATUS_READ, 16);
		while (rd[0] !== 1'b0 && k < 20)
		begin
			cycles(100);
			cmd(`CMD_STATUS_READ, 16);
			k++;
		end
	endtask : poll_idle
	initial
	begin
		rst_n = 1'b0;
		write_protect_n = 1'b1;
		array_cycle_busy = 1'b0;
		array_cycle_done = 1'b0;
		array_addr_protected = 1'b0;
		cycles(12);
		rst_n = 1'b1;
		cycles(5);
		check(status_register, 8'h00);
		foreach (rows[i])
		begin
			cycles(2);
			write_protect_n = rows[i].wp;
			cmd(`CMD_LATCH_SET, 8);
			status_write_cmd(rows[i].data, 16);
			poll_idle();
			check(rd[7:0], rows[i].sr);
			check(hardware_locked_mode, rows[i].hw);
		end
		cmd(`CMD_LATCH_SET, 8);
		cmd(`CMD_STATUS_READ, 16);
		check(rd[7:0], 8'h02);
		cmd(`CMD_LATCH_CLEAR, 8);
		status_write_cmd(8'hff, 16);
		cycles(5);
		check(status_register, 8'h00);
		cmd(`CMD_LATCH_SET, 8);
		status_write_cmd(8'hff, 15);
		cmd(`CMD_LATCH_CLEAR, 9);
		cycles(5);
		check(status_register, 8'h02);
		status_write_cmd(8'h9c, 16);
		cmd(`CMD_STATUS_READ, 24);
		check(rd, 16'h9f9f);
		cycles(TW);
		check(status_register, 8'h9c);
		cmd(`CMD_LATCH_SET, 8);
		cmd(`CMD_CHIP_WIPE, 8);
		check(16'(grants), 16'h0000);
		status_write_cmd(8'h00, 16);
		cycles(TW + 50);
		cmd(`CMD_LATCH_SET, 8);
		cmd(`CMD_CHIP_WIPE, 8);
		check(16'(grants), 16'h0001);
		cycles(1);
		array_cycle_busy = 1'b1;
		cycles(3);
		check(status_register[0], 1'b1);
		array_cycle_busy = 1'b0;
		array_cycle_done = 1'b1;
		cycles(1);
		array_cycle_done = 1'b0;
		cycles(4);
		check(status_register, 8'h00);
		cycles(1);
		array_addr_protected = 1'b1;
		cmd(`CMD_LATCH_SET, 8);
		cmd(`CMD_PAGE_PROGRAM, 32);
		check(16'(pgrants), 16'h0000);
		cycles(1);
		array_addr_protected = 1'b0;
		cmd(`CMD_PAGE_PROGRAM, 32);
		check(16'(pgrants), 16'h0001);
		cmd(`CMD_LATCH_CLEAR, 8);
		cmd(`CMD_PAGE_PROGRAM, 32);
		check(16'(pgrants), 16'h0001);
		cmd(`CMD_LATCH_SET, 8);
		cmd(`CMD_STATUS_READ, 16);
		check(serial_data_oe, 1'b0);
		check(rd[7:0], 8'h02);
		cycles(1);
		rst_n = 1'b0;
		cycles(3);
		rst_n = 1'b1;
		cycles(5);
		check(status_register, 8'h00);
		tally_and_finish();
	end
endmodule : serial_flash_status_protect_test
